// ==== core/bsg_glue.sv ====
`timescale 1ns/100ps
module bsg_glue (
	// Clock and resets
	input  wire logic              ref_clk_in,
	input  wire logic              rst_in,
	input  wire logic              wdog_reset_in,
	// Straps and flash pins (asynchronous)
	input  wire logic              boot_select_strap_in,
	input  wire logic              tristate_strap_n_in,
	input  wire logic              flash_select_n_in,
	input  wire logic              flash_reset_n_in,
	// Flash die activity
	input  wire logic              flash_op_active_in,
	// Bus controller
	input  wire bsg_pkg::bsg_bus_t bus_in,
	input  wire logic              cs_mode_in,
	input  wire logic              byte_write_mode_in,
	// Pins
	output logic [3:0]             upper_chip_selects_out,
	output logic                   upper_oe_n_out,
	output logic                   low_byte_write_n_out,
	output logic                   high_byte_write_n_out,
	output logic                   strobe_oe_n_out,
	output logic                   flash_busy_n_out,
	output logic                   flash_busy_oe_n_out,
	// Status
	output logic                   boot_flash_out,
	output logic                   tri_mode_out,
	output logic                   fetch_ok_out,
	output logic                   flash_enabled_out,
	output logic                   flash_read_mode_out
);
	localparam int unsigned CNT_W = bsg_pkg::CNT_W;

	// Active-low write strobe for one byte lane; shared by both lanes
	function automatic logic wr_strobe_n(
		input bsg_pkg::bsg_bus_t bus,
		input logic              byte_mode,
		input logic              lane_en
	);
		return !(bus.valid && bus.write && byte_mode && lane_en);
	endfunction : wr_strobe_n

	bsg_pkg::bsg_state_t st_reg;
	logic [1:0]          rst_sync_reg;
	logic                rst_hold;
	logic [CNT_W-1:0]    hold_cnt_reg;
	bsg_pkg::bsg_state_t st_next;
	logic [1:0] sync_a_reg;
	logic [1:0] sync_b_reg;
	logic [1:0] sync_c_reg;
	logic [1:0] sync_d_reg;
	logic [1:0] sync_e_reg;
	logic       boot_s;
	logic       tri_n_s;
	logic       fsel_n_s;
	logic       frst_n_s;
	logic       wdog_s;

	// Straps must be seen while reset is held, so these stages are never reset
	always_ff @(posedge ref_clk_in) begin
		sync_a_reg <= {sync_a_reg[0], boot_select_strap_in};
		sync_b_reg <= {sync_b_reg[0], tristate_strap_n_in};
		sync_c_reg <= {sync_c_reg[0], flash_select_n_in};
		sync_d_reg <= {sync_d_reg[0], flash_reset_n_in};
		sync_e_reg <= {sync_e_reg[0], wdog_reset_in};
	end

	// Reset enters at once, leaves in step with the clock
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			rst_sync_reg <= 2'h3;
		end else begin
			rst_sync_reg <= {rst_sync_reg[0], 1'b0};
		end
	end
	assign rst_hold = rst_sync_reg[1];

	// Tri-state strap low-time counter; runs only while reset is held
	always_ff @(posedge ref_clk_in) begin
		if (!(rst_in || rst_hold)) begin
			hold_cnt_reg <= hold_cnt_reg;
		end else if (tri_n_s) begin
			hold_cnt_reg <= '0;
		end else if (hold_cnt_reg != {CNT_W{1'b1}}) begin
			hold_cnt_reg <= hold_cnt_reg + 1'b1;
		end
	end
	assign boot_s   = sync_a_reg[1];
	assign tri_n_s  = sync_b_reg[1];
	assign fsel_n_s = sync_c_reg[1];
	assign frst_n_s = sync_d_reg[1];
	assign wdog_s   = sync_e_reg[1];

	always_comb begin
		st_next = st_reg;
		case (st_reg.phase)
			// Release edge: straps are taken here only
			bsg_pkg::BSG_IN_RESET: begin
				st_next.tri_cnt = hold_cnt_reg;
				if (!rst_hold) begin
					st_next.boot_flash = ~boot_s;
					st_next.tri_mode = (hold_cnt_reg >= CNT_W'(bsg_pkg::TRI_HOLD_CYCLES))
						&& !tri_n_s;
					st_next.phase = bsg_pkg::BSG_WAIT;
					st_next.fetch_cnt = '0;
				end
			end
			bsg_pkg::BSG_WAIT: begin
				st_next.fetch_cnt = st_reg.fetch_cnt + 1'b1;
				if (st_reg.fetch_cnt == CNT_W'(bsg_pkg::FETCH_DELAY_CYCLES - 1)) begin
					st_next.fetch_ok = 1'b1;
					st_next.phase = bsg_pkg::BSG_RUN;
				end
			end
			bsg_pkg::BSG_RUN: begin
				// Watchdog restarts fetch timing, straps keep their values
				if (wdog_s) begin
					st_next.fetch_ok = 1'b0;
					st_next.fetch_cnt = '0;
					st_next.phase = bsg_pkg::BSG_WAIT;
				end
			end
			default: st_next.phase = bsg_pkg::BSG_IN_RESET;
		endcase
		st_next.cs_mode = st_reg.fetch_ok && cs_mode_in;
		st_next.upper_cs = st_reg.cs_mode ? bus_in.cs_hi : bus_in.addr_hi;
		if (!st_reg.fetch_ok)
			st_next.upper_cs = 4'h0;
		st_next.low_wr_n = wr_strobe_n(bus_in, byte_write_mode_in, bus_in.byte_en[0]);
		st_next.high_wr_n = wr_strobe_n(bus_in, byte_write_mode_in, bus_in.byte_en[1]);
		st_next.upper_oe_n = st_reg.tri_mode;
		st_next.strobe_oe_n = st_reg.tri_mode;
		st_next.flash_en = !fsel_n_s && frst_n_s;
		st_next.flash_read_mode = !frst_n_s || (st_reg.flash_read_mode
			&& !flash_op_active_in);
		st_next.busy_oe_n = !(frst_n_s && flash_op_active_in) || st_reg.tri_mode;
	end

	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			st_reg <= '{phase: bsg_pkg::BSG_IN_RESET, tri_cnt: '0, fetch_cnt: '0,
				boot_flash: bsg_pkg::BOOT_SEL_RESET, tri_mode: bsg_pkg::TRI_MODE_RESET,
				cs_mode: 1'b0, fetch_ok: 1'b0, upper_cs: 4'h0, low_wr_n: 1'b1,
				high_wr_n: 1'b1, upper_oe_n: 1'b0, strobe_oe_n: 1'b0, flash_en: 1'b0,
				flash_read_mode: 1'b1, busy_oe_n: 1'b1};
		end else begin
			st_reg <= st_next;
		end
	end

	// Pins and status come straight from the state register, except the busy pad level, which is tied low
	assign upper_chip_selects_out = st_reg.upper_cs;
	assign upper_oe_n_out         = st_reg.upper_oe_n;
	assign low_byte_write_n_out   = st_reg.low_wr_n;
	assign high_byte_write_n_out  = st_reg.high_wr_n;
	assign strobe_oe_n_out        = st_reg.strobe_oe_n;
	// Open drain: the pad only ever pulls low, the enable decides
	assign flash_busy_n_out       = 1'b0;
	assign flash_busy_oe_n_out    = st_reg.busy_oe_n;
	assign boot_flash_out         = st_reg.boot_flash;
	assign tri_mode_out           = st_reg.tri_mode;
	assign fetch_ok_out           = st_reg.fetch_ok;
	assign flash_enabled_out      = st_reg.flash_en;
	assign flash_read_mode_out    = st_reg.flash_read_mode;

	chk_upper_addr: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		(st_reg.fetch_ok && !st_reg.cs_mode)
		|=> upper_chip_selects_out == $past(bus_in.addr_hi))
		else $error("upper lines not carrying address bits");

	chk_read_on_reset: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		!frst_n_s |=> flash_read_mode_out)
		else $error("flash reset did not restore read mode");

	chk_busy_release: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		!flash_op_active_in |=> flash_busy_oe_n_out)
		else $error("busy line held after operation ended");

	chk_low_wr_gate: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		(!byte_write_mode_in || !bus_in.byte_en[0]) |=> low_byte_write_n_out)
		else $error("low byte strobe without low byte write");

	chk_high_wr_gate: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		(!byte_write_mode_in || !bus_in.byte_en[1]) |=> high_byte_write_n_out)
		else $error("high byte strobe without high byte write");

	chk_tri_oe_off: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		tri_mode_out |=> (upper_oe_n_out && strobe_oe_n_out && flash_busy_oe_n_out))
		else $error("driver enabled in tri-state mode");

	chk_straps_hold: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		(st_reg.phase != bsg_pkg::BSG_IN_RESET)
		|=> ($stable(boot_flash_out) && $stable(tri_mode_out)))
		else $error("strap values changed outside reset");

	chk_no_early_fetch: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		(st_reg.phase == bsg_pkg::BSG_IN_RESET) |-> !fetch_ok_out)
		else $error("fetch allowed during reset");

	chk_fetch_count: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		$rose(fetch_ok_out)
		|-> $past(st_reg.fetch_cnt) == CNT_W'(bsg_pkg::FETCH_DELAY_CYCLES - 1))
		else $error("fetch released after wrong cycle count");
endmodule : bsg_glue

// ==== shared/bsg_pkg.sv ====
package bsg_pkg;
	localparam int unsigned TRI_HOLD_CYCLES   = 80;
	localparam int unsigned FETCH_DELAY_CYCLES = 80;
	localparam int unsigned ADDR_HI_POS       = 20;
	localparam int unsigned CNT_W             = 8;
	localparam logic        BOOT_SEL_RESET    = 1'b1;
	localparam logic        TRI_MODE_RESET    = 1'b0;

	typedef enum logic [1:0] {
		BSG_IN_RESET = 2'b00,
		BSG_WAIT     = 2'b01,
		BSG_RUN      = 2'b10
	} bsg_phase_t;

	typedef struct packed {
		logic       valid;
		logic       write;
		logic [1:0] byte_en;
		logic [3:0] addr_hi;
		logic [3:0] cs_hi;
	} bsg_bus_t;

	typedef struct packed {
		bsg_phase_t       phase;
		logic [CNT_W-1:0] tri_cnt;
		logic [CNT_W-1:0] fetch_cnt;
		logic             boot_flash;
		logic             tri_mode;
		logic             cs_mode;
		logic             fetch_ok;
		logic [3:0]       upper_cs;
		logic             low_wr_n;
		logic             high_wr_n;
		logic             upper_oe_n;
		logic             strobe_oe_n;
		logic             flash_en;
		logic             flash_read_mode;
		logic             busy_oe_n;
	} bsg_state_t;
endpackage : bsg_pkg

// ==== test/bsg_board_model.sv ====
`timescale 1ns/100ps
module bsg_board_model (
	// Device pins
	input  wire logic [3:0] upper_chip_selects_in,
	input  wire logic       flash_busy_n_in,
	input  wire logic       flash_busy_oe_n_in,
	// Board nets
	output logic            flash_select_n_out,
	output logic            busy_line_out
);
	// Lowest upper select is wired to the flash die select
	assign flash_select_n_out = ~upper_chip_selects_in[0];
	// Pull-up holds the busy net high once released
	assign busy_line_out = flash_busy_oe_n_in ? 1'b1 : flash_busy_n_in;
endmodule : bsg_board_model

// ==== test/test_boot_strap_and_flash_die_glue.sv ====
`timescale 1ns/100ps
module test_boot_strap_and_flash_die_glue;
	typedef struct packed {
		logic              csm;
		bsg_pkg::bsg_bus_t bus;
		logic [3:0]        cs;
		logic              lw;
		logic              hw;
		logic              en;
	} bsg_row_t;
	localparam bsg_row_t ROWS [4] = '{'{1'b0, 12'hda5, 4'ha, 1'b0, 1'b1, 1'b0},
		'{1'b0, 12'he30, 4'h3, 1'b1, 1'b0, 1'b1}, '{1'b1, 12'hf09, 4'h9, 1'b0, 1'b0, 1'b1},
		'{1'b1, 12'hb06, 4'h6, 1'b1, 1'b1, 1'b0}};
	logic ref_clk_in = 1'b0, rst_in = 1'b1, wdog_reset_in = 1'b0, boot_select_strap_in = 1'b0;
	logic tristate_strap_n_in = 1'b1, flash_reset_n_in = 1'b1, flash_op_active_in = 1'b0;
	logic cs_mode_in = 1'b0, flash_select_n_in, busy_line, byte_write_mode_in = 1'b1;
	bsg_pkg::bsg_bus_t bus_in = '0;
	logic [3:0] upper_chip_selects_out;
	logic upper_oe_n_out, low_byte_write_n_out, high_byte_write_n_out, strobe_oe_n_out;
	logic flash_busy_n_out, flash_busy_oe_n_out, boot_flash_out, tri_mode_out, fetch_ok_out;
	logic flash_enabled_out, flash_read_mode_out;
	int num_errors = 0, n_compared = 0;
	always #20 ref_clk_in = ~ref_clk_in;
	bsg_glue i_bsg_glue (.ref_clk_in, .rst_in, .wdog_reset_in, .boot_select_strap_in,
		.tristate_strap_n_in, .flash_select_n_in, .flash_reset_n_in, .flash_op_active_in,
		.bus_in, .cs_mode_in, .byte_write_mode_in, .upper_chip_selects_out,
		.upper_oe_n_out, .low_byte_write_n_out, .high_byte_write_n_out, .strobe_oe_n_out,
		.flash_busy_n_out, .flash_busy_oe_n_out, .boot_flash_out, .tri_mode_out,
		.fetch_ok_out, .flash_enabled_out, .flash_read_mode_out);
	bsg_board_model i_bsg_board_model (.upper_chip_selects_in(upper_chip_selects_out),
		.flash_busy_n_in(flash_busy_n_out), .flash_busy_oe_n_in(flash_busy_oe_n_out),
		.flash_select_n_out(flash_select_n_in), .busy_line_out(busy_line));
	task automatic chk(input string nm, input logic [3:0] e, input logic [3:0] g);
		n_compared++;
		if (g !== e) begin
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
			num_errors++;
		end
	endtask : chk
	task automatic cyc(input int n);
		repeat (n) @(negedge ref_clk_in);
	endtask : cyc
	task automatic conclude;
		if (num_errors == 0 && n_compared > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : conclude
	initial begin
		cyc(16);
		rst_in = 1'b0;
		cyc(4);
		chk("boot_flash", 4'h1, {3'h0, boot_flash_out});
		chk("tri_mode", 4'h0, {3'h0, tri_mode_out});
		chk("upper_oe_n", 4'h0, {3'h0, upper_oe_n_out});
		chk("fetch_early", 4'h0, {3'h0, fetch_ok_out});
		cyc(90);
		chk("fetch_late", 4'h1, {3'h0, fetch_ok_out});
		for (int i = 0; i < 4; i++) begin
			cs_mode_in = ROWS[i].csm;
			bus_in = ROWS[i].bus;
			cyc(6);
			chk("upper_cs", ROWS[i].cs, upper_chip_selects_out);
			chk("low_wr_n", {3'h0, ROWS[i].lw}, {3'h0, low_byte_write_n_out});
			chk("high_wr_n", {3'h0, ROWS[i].hw}, {3'h0, high_byte_write_n_out});
			chk("flash_en", {3'h0, ROWS[i].en}, {3'h0, flash_enabled_out});
		end
		byte_write_mode_in = 1'b0;
		cyc(2);
		chk("low_wr_off", 4'h1, {3'h0, low_byte_write_n_out});
		chk("high_wr_off", 4'h1, {3'h0, high_byte_write_n_out});
		byte_write_mode_in = 1'b1;
		boot_select_strap_in = 1'b1;
		tristate_strap_n_in = 1'b0;
		wdog_reset_in = 1'b1;
		cyc(100);
		wdog_reset_in = 1'b0;
		cyc(2);
		chk("wdog_boot", 4'h1, {3'h0, boot_flash_out});
		chk("wdog_tri", 4'h0, {3'h0, tri_mode_out});
		flash_op_active_in = 1'b1;
		cyc(2);
		chk("busy_low", 4'h0, {3'h0, busy_line});
		flash_reset_n_in = 1'b0;
		cyc(4);
		chk("read_mode", 4'h1, {3'h0, flash_read_mode_out});
		flash_op_active_in = 1'b0;
		flash_reset_n_in = 1'b1;
		cyc(4);
		chk("busy_oe_n", 4'h1, {3'h0, flash_busy_oe_n_out});
		rst_in = 1'b1;
		#1 chk("async_rst", 4'h0, {3'h0, fetch_ok_out});
		cyc(100);
		rst_in = 1'b0;
		cyc(4);
		chk("tri_set", 4'h1, {3'h0, tri_mode_out});
		chk("tri_oe_n", 4'h1, {3'h0, upper_oe_n_out});
		chk("boot_ext", 4'h0, {3'h0, boot_flash_out});
		conclude;
	end
	initial begin
		cyc(2000);
		num_errors++;
		conclude;
	end
endmodule : test_boot_strap_and_flash_die_glue
